// file: fut_ctrl.sv
// user test, ECC check and modify-lock control with an APB register slave
// Functional notes
// RULE_01 - margin reads touch only blocks that are selected and not locked
// RULE_02 - margin level bit 0 biases against zeros, 1 against ones
// RULE_03 - locked blocks skipped; signature registers hold the checksum
// RULE_04 - writing the password to test control sets test enable
// RULE_05 - software enables, selects, sets margin, level, start, then polls done
// RULE_06 - software should keep linear sequence bit at 1 for margin reads
// RULE_07 - clearing start while busy aborts; done rises when abort ends
// RULE_08 - software ends margin read by clearing start, margin enable, level
// RULE_09 - ECC check drives forced word and syndrome, captures into signature
// RULE_10 - software writes word, syndrome, select, start, polls done, clears start
// RULE_11 - while done low, gated registers read indeterminate and ignore writes
// RULE_12 - every 32-bit word carries 7 check bits, single fix double detect
// RULE_13 - all-ones 39-bit codeword decodes as valid with no error
// RULE_14 - all-zero 39-bit codeword reports a double error
// RULE_15 - whole-byte clears of an erased word keep check bits 7F
// RULE_16 - the enhanced flag sequence also keeps check bits 7F
// RULE_17 - nonvolatile lock images load into volatile locks once after reset
// RULE_18 - volatile lock registers reset to the locked state
// RULE_19 - nonvolatile lock bits go 1 to 0 once only, delivered all ones
// RULE_20 - primary lock has one software bit per low and mid block
// RULE_21 - secondary lock applies to low blocks only
// RULE_22 - array reads during a test set the read-while-write error
// RULE_23 - control bits: enable 31, margin 5, level 4, ECC 3, start 1, done 0
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module fut_ctrl
	import fut_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             arr_rd_o,
	output logic      [6:0]  arr_addr_o,
	input  wire logic [38:0] arr_rdata_i,
	output logic             margin_active_o,
	output logic             margin_level_o,
	input  wire logic        user_read_i,
	output logic             rww_error_o,
	input  wire logic [7:0]  nv_primary_lock_i,
	input  wire logic [3:0]  nv_secondary_lock_i,
	output logic             nv_prog_o,
	output logic             nv_prog_sec_o,
	output logic      [7:0]  nv_prog_data_o,
	output logic      [7:0]  modify_lock_o,
	output logic             test_busy_o
);
	fut_state_t        state;
	logic              te, me, ml, ee, ls, st, dn;
	logic [6:0]        syn;
	logic [31:0]       word;
	logic [31:0]       sig0, sig1;
	logic [7:0]        sel;
	logic [7:0]        lock1;
	logic [3:0]        lock2;
	logic              rww;
	logic [2:0]        blk;
	logic [WORD_W-1:0] wrd, wrd_rev;
	logic              rd_pend;
	logic [7:0]        lock_eff, elig;
	logic              wr, wr_ctrl, launch, busy, scanning, issue;
	logic [31:0]       rd_val;
	logic              mapped;
	logic [31:0]       ecc_din, dec_data;
	logic [6:0]        ecc_cin, enc_chk, dec_syn;
	logic              dec_single, dec_double;

	////////////////////////////////////////////////////////////////////////////
	assign wr       = psel_i && penable_i && pwrite_i;
	assign wr_ctrl  = wr && (paddr_i == OFS_CTRL);
	assign busy     = !dn;
	assign scanning = (state == ST_SCAN) || (state == ST_DRAIN);
	assign launch   = wr_ctrl && te && pwdata_i[BIT_TE] && pwdata_i[BIT_ST] && !st && dn;
	assign issue    = (state == ST_SCAN) && st && elig[blk];

	genvar g;
	for (g = 0; g < NBLK; g++) begin : g_blk
		if (g < NLOW) begin : g_low
			assign lock_eff[g] = lock1[g] | lock2[g]; // RULE_21
		end else begin : g_mid
			assign lock_eff[g] = lock1[g]; // RULE_20
		end
		assign elig[g] = sel[g] & ~lock_eff[g]; // RULE_01
	end

	for (g = 0; g < WORD_W; g++) begin : g_rev
		assign wrd_rev[g] = wrd[WORD_W-1-g];
	end

	////////////////////////////////////////////////////////////////////////////
	// control register; gated fields only move while done is high
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			te  <= 1'b0;
			me  <= 1'b0;
			ml  <= 1'b0;
			ee  <= 1'b0;
			ls  <= 1'b0;
			st  <= 1'b0;
			syn <= 7'h00;
		end else if (wr_ctrl) begin
			if (!te) begin
				if (pwdata_i == TEST_PASSWORD) te <= 1'b1; // RULE_04
			end else if (!pwdata_i[BIT_TE]) begin
				te <= 1'b0;
				st <= 1'b0;
				if (!busy) {me, ml, ee, ls} <= 4'h0; // RULE_11
				if (!busy) syn <= 7'h00;
			end else begin
				st <= pwdata_i[BIT_ST]; // RULE_07
				if (!busy) begin // RULE_11
					me  <= pwdata_i[BIT_ME]; // RULE_23
					ml  <= pwdata_i[BIT_ML]; // RULE_02
					ee  <= pwdata_i[BIT_EE];
					ls  <= pwdata_i[BIT_LS];
					syn <= pwdata_i[SYN_LSB +: CHK_W];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer: scan of eligible blocks or one forced ECC evaluation
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state   <= ST_INIT;
			dn      <= 1'b1;
			blk     <= 3'h0;
			wrd     <= '0;
			rd_pend <= 1'b0;
			arr_rd_o   <= 1'b0;
			arr_addr_o <= 7'h00;
		end else begin
			rd_pend  <= arr_rd_o && scanning && st;
			arr_rd_o <= issue;
			if (issue) arr_addr_o <= {blk, ls ? wrd : wrd_rev};
			case (state)
				ST_INIT: begin
					state <= ST_IDLE;
				end
				ST_IDLE: begin
					if (launch) begin
						dn    <= 1'b0;
						blk   <= 3'h0;
						wrd   <= '0;
						state <= pwdata_i[BIT_EE] ? ST_ECC : ST_SCAN;
					end
				end
				ST_SCAN: begin
					if (!st) begin
						dn    <= 1'b1; // RULE_07
						state <= ST_IDLE;
					end else if (!elig[blk] || (wrd == '1)) begin // RULE_03
						wrd <= '0;
						if (blk == 3'(NBLK - 1)) state <= ST_DRAIN;
						else blk <= blk + 3'h1;
					end else begin
						wrd <= wrd + 1'b1;
					end
				end
				ST_DRAIN: begin
					if (!st || (!arr_rd_o && !rd_pend)) begin
						dn    <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_ECC: begin
					dn    <= 1'b1;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign margin_active_o = scanning && me;
	assign margin_level_o  = ml;
	assign test_busy_o     = busy;

	////////////////////////////////////////////////////////////////////////////
	// codec sees the forced inputs only during the ECC check
	assign ecc_din = (state == ST_ECC) ? word : arr_rdata_i[31:0];
	assign ecc_cin = (state == ST_ECC) ? syn : arr_rdata_i[38:32];

	fut_ecc u_ecc (
		.data_i   (ecc_din),
		.check_i  (ecc_cin),
		.data_o   (dec_data),
		.check_o  (enc_chk),
		.syn_o    (dec_syn),
		.single_o (dec_single),
		.double_o (dec_double)
	);

	// signatures: seedable while idle, accumulate raw data and flags while scanning
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sig0 <= 32'h0000_0000;
			sig1 <= 32'h0000_0000;
		end else if (state == ST_ECC) begin
			sig0 <= dec_data; // RULE_09
			sig1 <= {16'h0000, enc_chk, dec_double, dec_single, dec_syn};
		end else if (rd_pend && scanning) begin
			sig0 <= {sig0[30:0], 1'b0} ^ (sig0[31] ? MISR_TAPS : 32'h0) ^ arr_rdata_i[31:0];
			sig1 <= {sig1[30:0], 1'b0} ^ (sig1[31] ? MISR_TAPS : 32'h0)
				^ {23'h0, dec_double, dec_single, arr_rdata_i[38:32]}; // RULE_03
		end else if (wr && dn) begin
			if (paddr_i == OFS_SIG0) sig0 <= pwdata_i;
			if (paddr_i == OFS_SIG1) sig1 <= pwdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			word <= 32'h0000_0000;
			sel  <= 8'h00;
		end else if (wr) begin
			if ((paddr_i == OFS_WORD) && dn) word <= pwdata_i; // RULE_11
			if (paddr_i == OFS_SEL) sel <= pwdata_i[7:0];
		end
	end

	// locks start locked; the nonvolatile image is taken once on leaving init
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock1 <= LCK1_RST; // RULE_18
			lock2 <= LCK2_RST; // RULE_18
		end else if (state == ST_INIT) begin
			lock1 <= nv_primary_lock_i; // RULE_17
			lock2 <= nv_secondary_lock_i; // RULE_17
		end else if (wr) begin
			if (paddr_i == OFS_LCK1) lock1 <= pwdata_i[7:0]; // RULE_20
			if (paddr_i == OFS_LCK2) lock2 <= pwdata_i[3:0]; // RULE_21
		end
	end

	assign modify_lock_o = lock_eff;

	// one-time cells can only lose ones, so the request is anded with the image
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nv_prog_o      <= 1'b0;
			nv_prog_sec_o  <= 1'b0;
			nv_prog_data_o <= 8'hFF;
		end else begin
			nv_prog_o <= wr && ((paddr_i == OFS_NV1) || (paddr_i == OFS_NV2));
			if (wr && (paddr_i == OFS_NV1)) begin
				nv_prog_sec_o  <= 1'b0;
				nv_prog_data_o <= nv_primary_lock_i & pwdata_i[7:0]; // RULE_19
			end else if (wr && (paddr_i == OFS_NV2)) begin
				nv_prog_sec_o  <= 1'b1;
				nv_prog_data_o <= {4'hF, nv_secondary_lock_i & pwdata_i[3:0]}; // RULE_19
			end
		end
	end

	// set beats a same-cycle write-one-to-clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rww <= 1'b0;
		end else if (user_read_i && busy) begin
			rww <= 1'b1; // RULE_22
		end else if (wr && (paddr_i == OFS_STAT) && pwdata_i[0]) begin
			rww <= 1'b0;
		end
	end

	assign rww_error_o = rww;

	////////////////////////////////////////////////////////////////////////////
	// gated fields read as zero while busy; that stands in for indeterminate data
	always_comb begin
		rd_val = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr_i)
			OFS_CTRL: begin
				rd_val[BIT_TE] = te;
				rd_val[BIT_ST] = st;
				rd_val[BIT_DN] = dn;
				if (dn) begin
					rd_val[BIT_ME] = me;
					rd_val[BIT_ML] = ml;
					rd_val[BIT_EE] = ee;
					rd_val[BIT_LS] = ls;
					rd_val[SYN_LSB +: CHK_W] = syn;
				end
			end
			OFS_WORD: rd_val = dn ? word : 32'h0000_0000; // RULE_11
			OFS_SIG0: rd_val = dn ? sig0 : 32'h0000_0000;
			OFS_SIG1: rd_val = dn ? sig1 : 32'h0000_0000;
			OFS_SEL:  rd_val[7:0] = sel;
			OFS_LCK1: rd_val[7:0] = lock1;
			OFS_LCK2: rd_val[3:0] = lock2;
			OFS_STAT: rd_val[0] = rww;
			OFS_NV1:  rd_val[7:0] = nv_primary_lock_i;
			OFS_NV2:  rd_val[3:0] = nv_secondary_lock_i;
			default:  mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) prdata_o <= 32'h0000_0000;
		else if (psel_i && !penable_i && !pwrite_i) prdata_o <= rd_val;
	end

	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;

	////////////////////////////////////////////////////////////////////////////
	a_pw_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_04
		(wr_ctrl && !te && pwdata_i == TEST_PASSWORD) |=> te)
		else $error("password write did not enable test mode");

	a_locked_skip: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_01
		arr_rd_o |-> elig[arr_addr_o[6:4]] || !st)
		else $error("array read issued to an ineligible block");

	a_margin_level: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_02
		(arr_rd_o && me) |-> margin_active_o && (margin_level_o == ml))
		else $error("margin read without margin bias");

	a_abort_done: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_07
		(scanning && !st) |=> dn && (state == ST_IDLE))
		else $error("abort did not raise done");

	a_gate_word: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_11
		(busy && wr && paddr_i == OFS_WORD) |=> $stable(word))
		else $error("word input changed while busy");

	a_ecc_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_09
		(launch && pwdata_i[BIT_EE]) |=> ##1 (sig0 == $past(dec_data)) && dn)
		else $error("forced ECC result not captured");

	a_erased_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_13
		(state != ST_ECC && arr_rdata_i == '1) |-> !dec_single && !dec_double)
		else $error("erased word flagged as error");

	a_zero_dbl: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_14
		(state != ST_ECC && arr_rdata_i == '0) |-> dec_double)
		else $error("all-zero word not a double error");

	a_nv_load: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_17
		(state == ST_INIT) |=> lock1 == $past(nv_primary_lock_i))
		else $error("volatile lock not loaded from image");

	a_nv_oneway: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_19
		(nv_prog_o && !nv_prog_sec_o) |-> (nv_prog_data_o & ~$past(nv_primary_lock_i)) == 8'h00)
		else $error("one-time lock bit would go 0 to 1");

	a_rww_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_22
		(user_read_i && busy) |=> rww_error_o)
		else $error("read during test did not flag error");
endmodule : fut_ctrl

// file: fut_pkg.sv
// package: register map, field positions, reset values, code table and states
package fut_pkg;
	localparam int          DATA_W   = 32;
	localparam int          CHK_W    = 7;
	localparam int          NBLK     = 8;
	localparam int          NLOW     = 4;
	localparam int          WORD_W   = 4;
	localparam int          ADDR_W   = 8;

	localparam logic [7:0]  OFS_CTRL = 8'h00;
	localparam logic [7:0]  OFS_WORD = 8'h04;
	localparam logic [7:0]  OFS_SIG0 = 8'h08;
	localparam logic [7:0]  OFS_SIG1 = 8'h0C;
	localparam logic [7:0]  OFS_SEL  = 8'h10;
	localparam logic [7:0]  OFS_LCK1 = 8'h14;
	localparam logic [7:0]  OFS_LCK2 = 8'h18;
	localparam logic [7:0]  OFS_STAT = 8'h1C;
	localparam logic [7:0]  OFS_NV1  = 8'h20;
	localparam logic [7:0]  OFS_NV2  = 8'h24;

	localparam logic [31:0] TEST_PASSWORD = 32'hF9F99999;

	localparam int          BIT_TE   = 31;
	localparam int          BIT_ME   = 5;
	localparam int          BIT_ML   = 4;
	localparam int          BIT_EE   = 3;
	localparam int          BIT_LS   = 2;
	localparam int          BIT_ST   = 1;
	localparam int          BIT_DN   = 0;
	localparam int          SYN_LSB  = 16;

	localparam logic [7:0]  LCK1_RST = 8'hFF;
	localparam logic [3:0]  LCK2_RST = 4'hF;
	localparam logic [31:0] MISR_TAPS = 32'h00200003;

	// every byte's columns xor to zero, so whole-byte clears keep the check bits
	localparam logic [6:0] ECC_COL [0:31] = '{
		7'h13, 7'h07, 7'h0B, 7'h34, 7'h23, 7'h1C, 7'h38, 7'h2C,
		7'h43, 7'h45, 7'h4A, 7'h4C, 7'h19, 7'h29, 7'h52, 7'h62,
		7'h51, 7'h61, 7'h16, 7'h26, 7'h0D, 7'h15, 7'h2A, 7'h32,
		7'h25, 7'h54, 7'h31, 7'h64, 7'h0E, 7'h1A, 7'h58, 7'h68};

	typedef enum logic [4:0] {
		ST_INIT  = 5'b00001,
		ST_IDLE  = 5'b00010,
		ST_SCAN  = 5'b00100,
		ST_DRAIN = 5'b01000,
		ST_ECC   = 5'b10000
	} fut_state_t;
endpackage : fut_pkg

// file: fut_ecc.sv
// SEC-DED codec for one 32-bit word with 7 check bits
`timescale 1ns/1ps
module fut_ecc
	import fut_pkg::*;
(
	input  wire logic [31:0] data_i,
	input  wire logic [6:0]  check_i,
	output logic      [31:0] data_o,
	output logic      [6:0]  check_o,
	output logic      [6:0]  syn_o,
	output logic             single_o,
	output logic             double_o
);
	logic [31:0] flip;
	logic        hit;
	logic        chk_err;
	logic        zero_word;

	genvar j;
	genvar i;
	////////////////////////////////////////////////////////////////////////////
	// each row has even weight, so the inverted parity gives 7F for all ones
	for (j = 0; j < CHK_W; j++) begin : g_chk
		logic p;
		always_comb begin
			p = 1'b0;
			for (int k = 0; k < DATA_W; k++) begin
				p = p ^ (data_i[k] & ECC_COL[k][j]);
			end
		end
		assign check_o[j] = ~p; // RULE_12 RULE_15 RULE_16
	end

	for (i = 0; i < DATA_W; i++) begin : g_fix
		assign flip[i] = (syn_o == ECC_COL[i]);
	end

	////////////////////////////////////////////////////////////////////////////
	assign syn_o     = check_o ^ check_i;
	assign zero_word = (data_i == 32'h0000_0000) && (check_i == 7'h00);
	assign hit       = |flip;
	assign chk_err   = $onehot(syn_o);
	assign data_o    = zero_word ? data_i : (data_i ^ flip); // RULE_12
	assign single_o  = !zero_word && (hit || chk_err); // RULE_13
	assign double_o  = zero_word || ((syn_o != 7'h00) && !hit && !chk_err); // RULE_14
endmodule : fut_ecc

// file: fut_ctrl_tb.sv
// self-checking bench for the user test, ECC check and block lock control
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fut_ctrl_tb
	import fut_pkg::*;
;
	logic        clk_i      = 1'b0;
	logic        rst_n_i    = 1'b0;
	logic        psel_i     = 1'b0;
	logic        penable_i  = 1'b0;
	logic        pwrite_i   = 1'b0;
	logic [7:0]  paddr_i    = 8'h00;
	logic [31:0] pwdata_i   = 32'h00000000;
	logic [38:0] arr_rdata  = 39'h7FFFFFFFFF;
	logic        user_rd    = 1'b0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, arr_rd_o, margin_active_o, margin_level_o;
	logic        rww_error_o, nv_prog_o, nv_prog_sec_o, test_busy_o;
	logic [6:0]  arr_addr_o;
	logic [7:0]  nv_prog_data_o, modify_lock_o;
	int          bad_count, checked, rd_base;
	int          rd_cnt     = 0;
	logic [7:0]  seen_blk   = 8'h00;
	logic [7:0]  nv_data;
	logic        lvl_ok     = 1'b1;
	logic        nv_seen    = 1'b0;
	logic        nv_sec, last_err;
	logic [31:0] rd, sig0, sig1;

	always #25 clk_i = ~clk_i;

	fut_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .arr_rd_o(arr_rd_o),
		.arr_addr_o(arr_addr_o), .arr_rdata_i(arr_rdata), .margin_active_o(margin_active_o),
		.margin_level_o(margin_level_o), .user_read_i(user_rd), .rww_error_o(rww_error_o),
		.nv_primary_lock_i(8'hF0), .nv_secondary_lock_i(4'hC), .nv_prog_o(nv_prog_o),
		.nv_prog_sec_o(nv_prog_sec_o), .nv_prog_data_o(nv_prog_data_o),
		.modify_lock_o(modify_lock_o), .test_busy_o(test_busy_o));

	// records every array read and lock programming request
	always @(posedge clk_i) begin
		if (arr_rd_o === 1'b1) begin
			rd_cnt   <= rd_cnt + 1;
			seen_blk <= seen_blk | (8'h01 << arr_addr_o[6:4]);
			lvl_ok   <= lvl_ok & margin_active_o & margin_level_o;
		end
		if (nv_prog_o === 1'b1) begin
			nv_seen <= 1'b1;
			nv_data <= nv_prog_data_o;
			nv_sec  <= nv_prog_sec_o;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_flag(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : cmp_flag

	// request held from setup until pready is seen high at a rising edge
	task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		int n;
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			$display("CHECK FAILED at %0t: bus wait ran out", $time);
			give_verdict();
		end
		rdat      = prdata_o;
		last_err  = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb_xfer

	task automatic apb_wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] dummy;
		apb_xfer(1'b1, a, wd, dummy);
	endtask : apb_wr

	task automatic apb_rd(input logic [7:0] a, output logic [31:0] rdat);
		apb_xfer(1'b0, a, 32'h00000000, rdat);
	endtask : apb_rd

	task automatic poll_done(input int bound);
		int n;
		n = 0;
		do begin
			apb_rd(OFS_CTRL, rd);
			n++;
		end while (rd[BIT_DN] !== 1'b1 && n < bound);
		if (rd[BIT_DN] !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED at %0t: done never rose", $time);
			give_verdict();
		end
	endtask : poll_done

	task automatic run_ecc(input logic [31:0] word, input logic [6:0] syn);
		logic [31:0] ctl;
		ctl = 32'h80000008 | {9'h000, syn, 16'h0000};
		apb_wr(OFS_WORD, word);
		apb_wr(OFS_CTRL, ctl);
		apb_wr(OFS_CTRL, ctl | 32'h00000002);
		poll_done(8);
		apb_rd(OFS_SIG0, sig0);
		apb_rd(OFS_SIG1, sig1);
		apb_wr(OFS_CTRL, ctl);
	endtask : run_ecc

	function automatic logic [31:0] misr_run(input logic [31:0] d, input int n);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = 0; i < n; i++)
			m = {m[30:0], 1'b0} ^ (m[31] ? MISR_TAPS : 32'h00000000) ^ d;
		return m;
	endfunction : misr_run
////////////////////////////////////////////////////////////////////////////////
	logic [31:0] byte_clr [0:8] = '{32'hFFFFFFFF, 32'hFFFFFF00, 32'hFFFF00FF, 32'hFF00FFFF,
		32'h00FFFFFF, 32'hFFFF0000, 32'h0000FFFF, 32'hFF000000, 32'h000000FF};
	logic [31:0] flag_seq [0:3] = '{32'hFFFFFFB1, 32'hFF00FF00, 32'hCA00FF00, 32'h0000FF00};

	initial begin
		bad_count = 0;
		checked   = 0;
		repeat (2) @(posedge clk_i);
		cmp_word({24'h0, modify_lock_o}, 32'h000000FF);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		apb_rd(OFS_LCK1, rd);
		cmp_word(rd, 32'h000000F0);
		apb_rd(OFS_LCK2, rd);
		cmp_word(rd, 32'h0000000C);
		apb_wr(OFS_LCK1, 32'h0000005A);
		apb_wr(OFS_LCK2, 32'h00000003);
		@(negedge clk_i);
		cmp_word({24'h0, modify_lock_o}, 32'h0000005B);
		apb_wr(OFS_NV1, 32'h0000000F);
		repeat (3) @(posedge clk_i);
		cmp_word({23'h0, nv_sec, nv_data}, 32'h00000000);
		apb_wr(OFS_NV2, 32'h00000003);
		repeat (3) @(posedge clk_i);
		cmp_word({22'h0, nv_seen, nv_sec, nv_data}, 32'h000003F0);
		$display("test locks finished");

		apb_wr(OFS_CTRL, 32'h80000002);
		apb_rd(OFS_CTRL, rd);
		cmp_word(rd, 32'h00000001);
		apb_wr(OFS_CTRL, TEST_PASSWORD);
		apb_rd(OFS_CTRL, rd);
		cmp_word(rd & 32'h80000001, 32'h80000001);
		for (int i = 0; i < 9; i++) begin
			run_ecc(byte_clr[i], 7'h7F);
			cmp_word(sig0, byte_clr[i]);
			cmp_word(sig1, 32'h0000FE00);
		end
		for (int i = 0; i < 4; i++) begin
			run_ecc(flag_seq[i], 7'h7F);
			cmp_word(sig1, 32'h0000FE00);
		end
		run_ecc(32'h00000000, 7'h00);
		cmp_word(sig1 & 32'h00000100, 32'h00000100);
		run_ecc(32'hFFFFFFFE, 7'h7F);
		cmp_word(sig0, 32'hFFFFFFFF);
		cmp_word(sig1 & 32'h00000180, 32'h00000080);
		run_ecc(32'h55555555, 7'h38);
		cmp_word(sig0, 32'h55555555);
		$display("test ecc finished");

		apb_wr(OFS_LCK1, 32'h00000002);
		apb_wr(OFS_LCK2, 32'h00000000);
		apb_wr(OFS_SEL, 32'h00000003);
		apb_wr(OFS_SIG0, 32'h00000000);
		apb_wr(OFS_SIG1, 32'h00000000);
		apb_wr(OFS_CTRL, 32'h80000024);
		@(negedge clk_i);
		cmp_flag(margin_level_o, 1'b0);
		apb_wr(OFS_CTRL, 32'h80000034);
		apb_wr(OFS_CTRL, 32'h80000036);
		apb_wr(OFS_WORD, 32'h12345678);
		apb_rd(OFS_SIG0, rd);
		cmp_word(rd, 32'h00000000);
		user_rd <= 1'b1;
		@(posedge clk_i);
		user_rd <= 1'b0;
		poll_done(60);
		cmp_word(rd_cnt, 32'd16);
		cmp_word({24'h0, seen_blk}, 32'h00000001);
		cmp_flag(lvl_ok, 1'b1);
		cmp_flag(rww_error_o, 1'b1);
		apb_rd(OFS_SIG0, rd);
		cmp_word(rd, misr_run(32'hFFFFFFFF, 16));
		apb_rd(OFS_SIG1, rd);
		cmp_word(rd, misr_run(32'h0000007F, 16));
		apb_wr(OFS_CTRL, 32'h80000004);
		apb_rd(OFS_WORD, rd);
		cmp_word(rd, 32'h55555555);
		apb_wr(OFS_STAT, 32'h00000001);
		apb_rd(OFS_STAT, rd);
		cmp_word(rd & 32'h00000001, 32'h00000000);
		$display("test margin finished");

		rd_base = rd_cnt;
		apb_wr(OFS_LCK1, 32'h00000000);
		apb_wr(OFS_SEL, 32'h000000FF);
		apb_wr(OFS_CTRL, 32'h80000036);
		repeat (10) @(posedge clk_i);
		apb_rd(OFS_CTRL, rd);
		cmp_flag(rd[BIT_DN], 1'b0);
		apb_wr(OFS_CTRL, 32'h80000034);
		poll_done(3);
		cmp_flag((rd_cnt - rd_base) < 128, 1'b1);
		apb_wr(OFS_CTRL, 32'h00000000);
		arr_rdata <= 39'h00_0000_0000;
		@(posedge clk_i);
		arr_rdata <= 39'h7F_FFFF_FFFF;
		apb_rd(OFS_CTRL, rd);
		cmp_word(rd, 32'h00000001);
		apb_rd(8'h30, rd);
		cmp_flag(last_err, 1'b1);
		cmp_word(rd, 32'h00000000);
		$display("test abort finished");
		give_verdict();
	end
endmodule : fut_ctrl_tb
